/* File: verilog/fan_pwm_fault_supervisor.sv */
`timescale 1ns/100ps
`default_nettype none
module fan_pwm_fault_supervisor #(
  parameter int STEP_TICKS = 6667
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [fan_ctrl_pkg::DUTY_W-1:0] duty_demand,
  input wire logic below_shutdown_threshold,
  input wire logic above_release_threshold,
  input wire logic below_autoshutdown_threshold_input,
  input wire logic above_autoshutdown_hysteresis,
  input wire logic fan_pulse,
  output logic fan_drive,
  output logic fault_out,
  output logic fault_oe,
  output logic in_shutdown,
  output logic in_autoshutdown,
  output logic fault_latched
);
  import fan_ctrl_pkg::*;

  // --------------------------------------------------
  // input synchronisers
  // --------------------------------------------------
  logic [4:0] raw_in;
  logic [4:0] syn;
  logic shdn_s, rel_s, as_s, ash_s, pulse_s;
  assign raw_in = {below_shutdown_threshold, above_release_threshold,
                   below_autoshutdown_threshold_input, above_autoshutdown_hysteresis,
                   fan_pulse};
  sync2 #(.W(5)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(raw_in),
    .q(syn)
  );
  assign {shdn_s, rel_s, as_s, ash_s, pulse_s} = syn;

  // --------------------------------------------------
  // shutdown latch with threshold hysteresis
  // --------------------------------------------------
  logic shdn_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shdn_r <= 1'b0;
    end else if (shdn_s) begin
      shdn_r <= 1'b1;
    end else if (rel_s) begin
      shdn_r <= 1'b0;
    end
  end

  // --------------------------------------------------
  // pwm timebase
  // --------------------------------------------------
  state_type state_r, state_nxt;
  logic running;
  logic period_start;
  logic pwm_on;
  logic [DUTY_W-1:0] duty_eff;
  assign running = (state_r == ST_START1) || (state_r == ST_START2) ||
                   (state_r == ST_RUN) || (state_r == ST_DIAG);
  assign duty_eff = duty_demand;
  pwm_timebase #(.STEP_TICKS(STEP_TICKS)) u_pwm (
    .clk(clk),
    .rst_n(rst_n),
    .run(running),
    .duty(duty_eff),
    .period_start(period_start),
    .pwm_on(pwm_on)
  );

  // --------------------------------------------------
  // pulse edge detect and blanking
  // --------------------------------------------------
  logic pulse_d_r;
  logic pwm_d_r;
  logic [3:0] blank_r;
  logic pulse_ok;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pulse_d_r <= 1'b0;
      pwm_d_r <= 1'b0;
      blank_r <= '0;
    end else begin
      pulse_d_r <= pulse_s;
      pwm_d_r <= pwm_on;
      if (pwm_on && !pwm_d_r) begin
        blank_r <= BLANK_TICKS;
      end else if (blank_r != 4'h0) begin
        blank_r <= blank_r - 4'h1;
      end
    end
  end
  assign pulse_ok = pulse_s && !pulse_d_r && (blank_r == 4'h0) && running;

  // --------------------------------------------------
  // supervisor state machine
  // --------------------------------------------------
  logic [5:0] cnt_r;
  logic cnt_done;
  logic [5:0] limit;
  always_comb begin
    case (state_r)
      ST_DIAG: limit = DIAG_PERIODS;
      ST_RUN: limit = MISS_PERIODS;
      default: limit = START_PERIODS;
    endcase
  end
  assign cnt_done = period_start && (cnt_r == limit - 6'h01);

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF: begin
        if (as_s) state_nxt = ST_AUTO;
        else if (ash_s) state_nxt = ST_START1;
      end
      ST_AUTO: begin
        if (ash_s) state_nxt = ST_START1;
      end
      ST_START1: begin
        if (pulse_ok) state_nxt = ST_RUN;
        else if (cnt_done) state_nxt = ST_START2;
      end
      ST_START2: begin
        if (pulse_ok) state_nxt = ST_RUN;
        else if (cnt_done) state_nxt = ST_FAULT;
      end
      ST_RUN: begin
        if (!pulse_ok && cnt_done) state_nxt = ST_DIAG;
      end
      ST_DIAG: begin
        if (pulse_ok) state_nxt = ST_RUN;
        else if (cnt_done) state_nxt = ST_START2;
      end
      ST_FAULT: state_nxt = ST_FAULT;
      default: state_nxt = ST_OFF;
    endcase
    if (as_s && running) state_nxt = ST_AUTO;
    if (shdn_r) state_nxt = ST_OFF;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= ST_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || state_nxt != state_r || pulse_ok) begin
      cnt_r <= '0;
    end else if (period_start) begin
      cnt_r <= cnt_r + 6'h01;
    end
  end

  // --------------------------------------------------
  // outputs
  // --------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fan_drive <= 1'b0;
      fault_oe <= 1'b0;
      fault_out <= 1'b0;
      in_shutdown <= 1'b0;
      in_autoshutdown <= 1'b0;
      fault_latched <= 1'b0;
    end else begin
      case (state_nxt)
        ST_START1, ST_START2, ST_DIAG: fan_drive <= 1'b1;
        ST_RUN: fan_drive <= pwm_on;
        default: fan_drive <= 1'b0;
      endcase
      fault_oe <= (state_nxt == ST_FAULT);
      fault_out <= 1'b0;
      in_shutdown <= shdn_r || (state_nxt == ST_FAULT);
      in_autoshutdown <= (state_nxt == ST_AUTO);
      fault_latched <= (state_nxt == ST_FAULT);
    end
  end
endmodule : fan_pwm_fault_supervisor
`default_nettype wire

/* File: verilog/fan_ctrl_pkg.sv */
// Overview of operation
// - duty rises 0 to 100 with level
// - fan drive output is active high
// - fault output open-drain, low on fault
// - supervisor timers count pwm periods, blanking counts clocks
// - start from off: drive on 32 periods
// - level at shutdown threshold: shutdown, fault released
// - shutdown stops pwm, timers, supervision
// - entering shutdown resets everything to power-up
// - leave shutdown at release threshold, then start
// - below auto-shutdown at release: stay auto-shutdown
// - level at auto-shutdown threshold: fan off
// - leave auto-shutdown above threshold plus hysteresis
// - auto-shutdown keeps fault output released
// - missing pulses in run are a fault
// - blank pulses caused by drive turn-on
// - 32 quiet periods: diagnostic, drive 3 periods
// - diagnostic without pulse: retry start-up burst
// - timeout again: stop, fault low, latch
// - latched fault cleared by shutdown cycle or reset only
// - reset clears fault whatever the auto-shutdown inputs
// - power-up: repeat start burst once before fault
// - each valid pulse restarts missing-pulse count
package fan_ctrl_pkg;
  localparam int DUTY_W = 8;
  localparam int PERIOD_TICKS = 1666667;
  localparam int PERIOD_W = 21;
  localparam int TICK_W = 13;
  localparam logic [TICK_W-1:0] TICKS_PER_STEP = 13'h1a2b;
  localparam logic [DUTY_W-1:0] DUTY_FULL = 8'hff;
  localparam logic [5:0] START_PERIODS = 6'h20;
  localparam logic [5:0] MISS_PERIODS = 6'h20;
  localparam logic [5:0] DIAG_PERIODS = 6'h03;
  localparam logic [3:0] BLANK_TICKS = 4'h8;
  typedef enum logic [6:0] {
    ST_OFF = 7'h01,
    ST_AUTO = 7'h02,
    ST_START1 = 7'h04,
    ST_START2 = 7'h08,
    ST_RUN = 7'h10,
    ST_DIAG = 7'h20,
    ST_FAULT = 7'h40
  } state_type;
endpackage : fan_ctrl_pkg

/* File: verilog/sync2.sv */
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      q <= '0;
    end else begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule : sync2
`default_nettype wire

/* File: verilog/pwm_timebase.sv */
`timescale 1ns/100ps
`default_nettype none
module pwm_timebase #(
  parameter int STEP_TICKS = 6667
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] duty,
  output logic period_start,
  output logic pwm_on
);
  import fan_ctrl_pkg::*;
  logic [TICK_W-1:0] tick_r;
  logic [DUTY_W-1:0] step_r;
  logic step_end;
  assign step_end = (tick_r == TICK_W'(STEP_TICKS - 1));
  // --------------------------------------------------
  // cycle counter, 255 steps a period
  // --------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      tick_r <= '0;
      step_r <= '0;
      period_start <= 1'b0;
      pwm_on <= 1'b0;
    end else begin
      period_start <= 1'b0;
      if (step_end) begin
        tick_r <= '0;
        if (step_r == DUTY_FULL - 8'h01) begin
          step_r <= '0;
          period_start <= 1'b1;
        end else begin
          step_r <= step_r + 8'h01;
        end
      end else begin
        tick_r <= tick_r + 13'h0001;
      end
      pwm_on <= (step_r < duty);
    end
  end
endmodule : pwm_timebase
`default_nettype wire

/* File: tb/fan_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// fan with sense network
// ----
module fan_model (
  input wire logic clk,
  input wire logic drive,
  input wire logic spin,
  output logic pulse
);
  logic [6:0] cnt_r;
  // commutation only while powered and turning; sense line rests low
  always_ff @(posedge clk) begin
    cnt_r <= (spin && drive) ? cnt_r + 7'h01 : 7'h00;
  end
  assign pulse = spin && cnt_r[6];
endmodule : fan_model
`default_nettype wire

/* File: tb/fan_pwm_fault_supervisor_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// port checks
// ----
module fan_pwm_fault_supervisor_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic below_shutdown_threshold,
  input wire logic fan_drive,
  input wire logic fault_out,
  input wire logic fault_oe,
  input wire logic in_shutdown,
  input wire logic in_autoshutdown,
  input wire logic fault_latched
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence leave_auto;
    $fell(in_autoshutdown) ##0 !in_shutdown;
  endsequence
  sequence burst;
    fan_drive [*8];
  endsequence
  fault_pol_a: assert property (!fault_out) else $error("fault data high");
  shdn_off_a: assert property (in_shutdown |-> !fan_drive) else $error("drive in shutdown");
  auto_quiet_a: assert property (in_autoshutdown |-> !fan_drive && !fault_oe)
    else $error("auto mode active");
  latch_out_a: assert property (fault_latched |-> fault_oe && !fan_drive)
    else $error("latched fault outputs wrong");
  fault_cause_a: assert property (fault_oe |-> fault_latched) else $error("fault without latch");
  latch_hold_a: assert property (fault_latched && !below_shutdown_threshold |=> fault_latched)
    else $error("latch dropped");
  shdn_entry_a: assert property (below_shutdown_threshold [*4] |=>
    in_shutdown && !fault_oe && !fan_drive) else $error("shutdown not entered");
  auto_burst_a: assert property (leave_auto |-> ##[0:3] burst) else $error("no start burst");
endmodule : fan_pwm_fault_supervisor_checker
bind fan_pwm_fault_supervisor fan_pwm_fault_supervisor_checker chk_inst (.clk(clk), .rst_n(rst_n),
  .below_shutdown_threshold(below_shutdown_threshold), .fan_drive(fan_drive),
  .fault_out(fault_out), .fault_oe(fault_oe), .in_shutdown(in_shutdown),
  .in_autoshutdown(in_autoshutdown), .fault_latched(fault_latched));
`default_nettype wire

/* File: tb/fan_pwm_fault_supervisor_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
// ----
// bench
// ----
module fan_pwm_fault_supervisor_tb_top;
  localparam int PER = 255 * 2;
  logic clk = 0, rst_n = 0, bshd = 0, arel = 1, bas = 0, hys = 1, spin = 1, pulse;
  logic fan_drive, fault_out, fault_oe, in_shutdown, in_autoshutdown, fault_latched;
  logic [7:0] duty = 8'hff;
  logic [9:0] hi;
  int err_count = 0, checks = 0, n;
  initial begin
    forever #10 clk = ~clk;
  end
  fan_pwm_fault_supervisor #(.STEP_TICKS(2)) fan_pwm_fault_supervisor_inst (.clk(clk),
    .rst_n(rst_n), .duty_demand(duty), .below_shutdown_threshold(bshd),
    .above_release_threshold(arel), .below_autoshutdown_threshold_input(bas),
    .above_autoshutdown_hysteresis(hys), .fan_pulse(pulse), .fan_drive(fan_drive),
    .fault_out(fault_out), .fault_oe(fault_oe), .in_shutdown(in_shutdown),
    .in_autoshutdown(in_autoshutdown), .fault_latched(fault_latched));
  fan_model fan_model_inst (.clk(clk), .drive(fan_drive), .spin(spin), .pulse(pulse));
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #2;
  endtask : cyc
  task automatic wait_hi(input string nm, ref logic s, input int lim, output int c);
    c = 0;
    while (s !== 1'b1) begin
      if (c == lim) begin
        chk(nm, 1, 0);
        conclude();
      end
      cyc(1);
      c++;
    end
  endtask : wait_hi
  task automatic meas(output logic [9:0] h);
    h = 0;
    repeat (PER) begin
      cyc(1);
      h += {9'h000, fan_drive};
    end
  endtask : meas
  initial begin
    cyc(12);
    rst_n = 1;
    wait_hi("start drive", fan_drive, 10, n);
    chk("idle fault", 0, fault_oe);
    cyc(1000);
    duty = 8'h00;
    cyc(PER + 10);
    meas(hi);
    chk("duty zero", 0, hi);
    wait_hi("diag drive", fan_drive, 17000, n);
    chk("diag late", 1, n > 14000);
    cyc(200);
    chk("diag pulse run", 0, fan_drive);
    chk("diag no fault", 0, fault_oe);
    duty = 8'hff;
    cyc(PER + 10);
    meas(hi);
    chk("duty full", PER, hi);
    bas = 1;
    hys = 0;
    cyc(8);
    chk("auto", 1, in_autoshutdown);
    chk("auto drive", 0, fan_drive);
    chk("auto fault", 0, fault_oe);
    bas = 0;
    cyc(20);
    chk("auto hold", 1, in_autoshutdown);
    hys = 1;
    spin = 0;
    wait_hi("restart", fan_drive, 10, n);
    cyc(16000);
    chk("burst", 1, fan_drive);
    wait_hi("latch", fault_latched, 17000, n);
    chk("second burst", 1, n > 16000);
    chk("fault low", 1, fault_oe);
    chk("fault drive", 0, fan_drive);
    arel = 0;
    bshd = 1;
    cyc(8);
    chk("shdn", 1, in_shutdown);
    chk("shdn fault", 0, fault_oe);
    chk("shdn latch", 0, fault_latched);
    bas = 1;
    hys = 0;
    bshd = 0;
    arel = 1;
    spin = 1;
    cyc(8);
    chk("rel auto", 1, in_autoshutdown);
    chk("rel drive", 0, fan_drive);
    bas = 0;
    hys = 1;
    wait_hi("rel start", fan_drive, 10, n);
    conclude();
  end
endmodule : fan_pwm_fault_supervisor_tb_top
`default_nettype wire
